// [design/afm_controller.sv]
// airflow meter controller: display multiplexer, tachometer timing, compensation, relay
//
// Operation
// - ~1000 Hz tick loads next segments and moves the enable to it on one edge, advances pointer.
// - pointer cycles four positions: tens, ones, tenths, discrete LEDs.
// - ~97 Hz slow tick counted; every 32nd sets update pending.
// - displayed values change only when update pending; flag cleared once taken.
// - tach pulse captures all 24 bits (upper 8 and low 16) of microsecond count, clears both.
// - 16-bit microsecond timer overflow increments the upper 8 bits.
// - upper 8 bits beyond limit means pulses stopped; set no-flow flag.
// - while no-flow is set, digits show three E characters.
// - flow from period minus capture latency, compensated by temperature ch1, then pressure ch0.
// - setpoint from ch2; relay closed when flow above setpoint, else open.
// - on update, pick shown value from buttons and no-flow; hand to multiplexer.
// - main loop forever: compute flow, compare and drive relay, service display.
// - buttons: both high flow, first low temp, second low pressure, both low setpoint.
`timescale 1ns/1ns
module afm_controller #(
    parameter int REFRESH_CYCLES = afm_pkg::REFRESH_CYCLES, // clocks per refresh tick
    parameter int SLOW_CYCLES = afm_pkg::SLOW_CYCLES        // clocks per slow tick
) (
    input wire logic clk,                  // 100 MHz system clock
    input wire logic rst,                  // asynchronous reset, active high
    input wire logic tach_n,               // tachometer pulse train, active low
    input wire logic btn_a_n,              // first button line, active low
    input wire logic btn_b_n,              // second button line, active low
    input wire logic adc_done,             // converter result valid, one cycle
    input wire logic [7:0] adc_data,       // converter result
    output logic adc_start,                // converter start pulse
    output logic [1:0] adc_chan,           // converter channel select
    output logic [7:0] seg,                // segment lines a..g, dp
    output logic [3:0] disp_en,            // position enables, all off from reset, then one-hot
    output logic relay,                    // relay drive, high closes
    output logic no_flow_flag              // tachometer pulses stopped
);
    // ---------------- timebase: refresh, slow tick, update pending
    logic [afm_pkg::REFRESH_W-1:0] refresh_cnt, next_refresh_cnt;
    logic [afm_pkg::SLOW_W-1:0] slow_cnt, next_slow_cnt;
    logic [4:0] slow_ticks, next_slow_ticks;
    logic update_pending, next_update_pending;
    logic refresh_tick_event, slow_tick_event, take_update;

    localparam logic [afm_pkg::REFRESH_W-1:0] REFRESH_LAST =
        afm_pkg::REFRESH_W'(REFRESH_CYCLES - 1);
    localparam logic [afm_pkg::SLOW_W-1:0] SLOW_LAST = afm_pkg::SLOW_W'(SLOW_CYCLES - 1);

    always_comb begin
        refresh_tick_event = (refresh_cnt == REFRESH_LAST);
        slow_tick_event = (slow_cnt == SLOW_LAST);
        next_refresh_cnt = refresh_tick_event ? '0 : refresh_cnt + 1'b1;
        next_slow_cnt = slow_tick_event ? '0 : slow_cnt + 1'b1;
        next_slow_ticks = slow_tick_event ? slow_ticks + 1'b1 : slow_ticks;
        next_update_pending = update_pending;
        if (take_update) begin
            next_update_pending = 1'b0;
        end
        // a set in the same cycle as the clear wins
        if (slow_tick_event && slow_ticks == afm_pkg::SLOW_PER_UPDATE_LAST) begin
            next_update_pending = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            refresh_cnt <= '0;
            slow_cnt <= '0;
            slow_ticks <= '0;
            update_pending <= 1'b0;
        end else begin
            refresh_cnt <= next_refresh_cnt;
            slow_cnt <= next_slow_cnt;
            slow_ticks <= next_slow_ticks;
            update_pending <= next_update_pending;
        end
    end

    // ---------------- tachometer period measurement
    logic [afm_pkg::US_W-1:0] us_cnt, next_us_cnt;
    logic [15:0] period_lo, next_period_lo;
    logic [7:0] period_hi, next_period_hi;
    logic [23:0] period, next_period;
    logic period_valid, next_period_valid;
    logic next_no_flow_flag;
    logic tach_prev, tach_pulse_event, us_tick, period_timer_overflow_event;

    always_comb begin
        tach_pulse_event = tach_prev && !tach_n;
        us_tick = (us_cnt == afm_pkg::US_LAST);
        period_timer_overflow_event = us_tick && (period_lo == afm_pkg::LO_MAX);
        next_us_cnt = us_tick ? '0 : us_cnt + 1'b1;
        next_period_lo = us_tick ? period_lo + 1'b1 : period_lo;
        next_period_hi = period_hi;
        next_period = period;
        next_period_valid = period_valid;
        next_no_flow_flag = no_flow_flag;
        // saturate so a stopped turbine cannot wrap back into range
        if (period_timer_overflow_event && period_hi != afm_pkg::HI_MAX) begin
            next_period_hi = period_hi + 1'b1;
        end
        if (period_hi > afm_pkg::NO_FLOW_LIMIT) begin
            next_no_flow_flag = 1'b1;
            next_period_valid = 1'b0;
        end
        if (tach_pulse_event) begin
            next_period = {period_hi, period_lo};
            next_period_lo = '0;
            next_period_hi = '0;
            next_us_cnt = '0;
            next_period_valid = !no_flow_flag;
            next_no_flow_flag = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            us_cnt <= '0;
            period_lo <= '0;
            period_hi <= '0;
            period <= '0;
            period_valid <= 1'b0;
            no_flow_flag <= 1'b0;
            tach_prev <= 1'b1;
        end else begin
            us_cnt <= next_us_cnt;
            period_lo <= next_period_lo;
            period_hi <= next_period_hi;
            period <= next_period;
            period_valid <= next_period_valid;
            no_flow_flag <= next_no_flow_flag;
            tach_prev <= tach_n;
        end
    end

    // ---------------- main loop: compute, compare, display
    afm_pkg::afm_main_type state, next_state;
    afm_pkg::afm_readings_type rd, next_rd;
    afm_pkg::afm_display_type shown, next_shown;
    afm_pkg::afm_view_type view;
    logic [15:0] flow, next_flow;
    logic next_relay, next_adc_start;
    logic [1:0] next_adc_chan;
    logic [23:0] period_corr;
    logic [31:0] quotient;
    logic [25:0] temp_prod;
    logic [24:0] pres_prod;
    logic [15:0] show_val;
    logic [15:0] setpoint_tenths;

    function automatic logic [15:0] clamp(input logic [31:0] v);
        clamp = (v > {16'h0000, afm_pkg::DISPLAY_MAX}) ? afm_pkg::DISPLAY_MAX : v[15:0];
    endfunction

    always_comb begin
        // the fixed capture latency comes off the period before inverting
        period_corr = (period > afm_pkg::CAPTURE_LATENCY_US) ?
            period - afm_pkg::CAPTURE_LATENCY_US : 24'h000001;
        quotient = afm_pkg::FLOW_SCALE / {8'h00, period_corr};
        temp_prod = flow * (afm_pkg::TEMP_BASE - {2'b00, adc_data});
        pres_prod = flow * (afm_pkg::PRES_BASE + {1'b0, adc_data});
        setpoint_tenths = {6'h00, rd.setpoint, 2'b00};
        case ({btn_a_n, btn_b_n})
            2'b01: view = afm_pkg::VIEW_TEMP;
            2'b10: view = afm_pkg::VIEW_PRES;
            2'b00: view = afm_pkg::VIEW_SET;
            default: view = afm_pkg::VIEW_FLOW;
        endcase
        case (view)
            afm_pkg::VIEW_TEMP: show_val = {8'h00, rd.temperature};
            afm_pkg::VIEW_PRES: show_val = {8'h00, rd.pressure};
            afm_pkg::VIEW_SET: show_val = clamp({16'h0000, setpoint_tenths});
            default: show_val = flow;
        endcase
        next_state = state;
        next_rd = rd;
        next_shown = shown;
        next_flow = flow;
        next_relay = relay;
        next_adc_start = 1'b0;
        next_adc_chan = adc_chan;
        take_update = 1'b0;
        case (state)
            afm_pkg::M_CALC: begin
                next_flow = (period_valid && !no_flow_flag) ? clamp(quotient) : '0;
                next_state = afm_pkg::M_TEMP_REQ;
            end
            afm_pkg::M_TEMP_REQ: begin
                next_adc_start = 1'b1;
                next_adc_chan = afm_pkg::CH_TEMPERATURE;
                next_state = afm_pkg::M_TEMP_WAIT;
            end
            afm_pkg::M_TEMP_WAIT: begin
                if (adc_done) begin
                    next_rd.temperature = adc_data;
                    next_flow = temp_prod[afm_pkg::COMP_SHIFT +: 16];
                    next_state = afm_pkg::M_PRES_REQ;
                end
            end
            afm_pkg::M_PRES_REQ: begin
                next_adc_start = 1'b1;
                next_adc_chan = afm_pkg::CH_PRESSURE;
                next_state = afm_pkg::M_PRES_WAIT;
            end
            afm_pkg::M_PRES_WAIT: begin
                if (adc_done) begin
                    next_rd.pressure = adc_data;
                    next_flow = clamp({16'h0000, pres_prod[afm_pkg::COMP_SHIFT +: 16]});
                    next_state = afm_pkg::M_SET_REQ;
                end
            end
            afm_pkg::M_SET_REQ: begin
                next_adc_start = 1'b1;
                next_adc_chan = afm_pkg::CH_SETPOINT;
                next_state = afm_pkg::M_SET_WAIT;
            end
            afm_pkg::M_SET_WAIT: begin
                if (adc_done) begin
                    next_rd.setpoint = adc_data;
                    next_relay = flow > {6'h00, adc_data, 2'b00};
                    next_state = afm_pkg::M_DISPLAY;
                end
            end
            afm_pkg::M_DISPLAY: begin
                if (update_pending) begin
                    take_update = 1'b1;
                    if (no_flow_flag) begin
                        next_shown.tens = afm_pkg::SEG_E;
                        next_shown.ones = afm_pkg::SEG_E;
                        next_shown.tenths = afm_pkg::SEG_E;
                    end else begin
                        next_shown.tens = afm_pkg::seg_of(4'(show_val / afm_pkg::HUNDRED));
                        next_shown.ones = afm_pkg::seg_of(
                            4'((show_val / afm_pkg::TEN) % afm_pkg::TEN)) | afm_pkg::SEG_DP;
                        next_shown.tenths = afm_pkg::seg_of(4'(show_val % afm_pkg::TEN));
                    end
                    case (view)
                        afm_pkg::VIEW_TEMP: next_shown.leds = afm_pkg::LED_TEMP;
                        afm_pkg::VIEW_PRES: next_shown.leds = afm_pkg::LED_PRES;
                        afm_pkg::VIEW_SET: next_shown.leds = afm_pkg::LED_SET;
                        default: next_shown.leds = afm_pkg::LED_FLOW;
                    endcase
                end
                next_state = afm_pkg::M_CALC;
            end
            default: next_state = afm_pkg::M_CALC;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= afm_pkg::M_CALC;
            rd <= '0;
            shown <= '0;
            flow <= '0;
            relay <= 1'b0;
            adc_start <= 1'b0;
            adc_chan <= afm_pkg::CH_PRESSURE;
        end else begin
            state <= next_state;
            rd <= next_rd;
            shown <= next_shown;
            flow <= next_flow;
            relay <= next_relay;
            adc_start <= next_adc_start;
            adc_chan <= next_adc_chan;
        end
    end

    // ---------------- display multiplexer
    afm_pkg::afm_pos_type pos, next_pos;
    logic [7:0] next_seg;
    logic [3:0] next_disp_en;

    always_comb begin
        next_pos = pos;
        next_seg = seg;
        if (refresh_tick_event) begin
            next_pos = afm_pkg::afm_pos_type'(pos + 2'h1);
            case (pos)
                afm_pkg::POS_TENS: next_seg = shown.ones;
                afm_pkg::POS_ONES: next_seg = shown.tenths;
                afm_pkg::POS_TENTHS: next_seg = shown.leds;
                default: next_seg = shown.tens;
            endcase
        end
    end

    // enable and segments change on the same edge, so no ghosting
    for (genvar i = 0; i < 4; i++) begin : g_en
        assign next_disp_en[i] = refresh_tick_event ? (next_pos == i) : disp_en[i];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos <= afm_pkg::POS_TENS;
            seg <= afm_pkg::SEG_OFF;
            disp_en <= '0;
        end else begin
            pos <= next_pos;
            seg <= next_seg;
            disp_en <= next_disp_en;
        end
    end
endmodule

// [shared/afm_pkg.sv]
// constants, types and helpers shared by the airflow meter controller
package afm_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int REFRESH_HZ = 1000;
    localparam int REFRESH_CYCLES = CLK_HZ / REFRESH_HZ;
    localparam int SLOW_HZ = 97;
    localparam int SLOW_CYCLES = CLK_HZ / SLOW_HZ;
    localparam int US_PER_S = 1_000_000;
    localparam int US_CYCLES = CLK_HZ / US_PER_S;
    localparam int REFRESH_W = 17;
    localparam int SLOW_W = 21;
    localparam int US_W = 7;
    localparam logic [US_W-1:0] US_LAST = US_W'(US_CYCLES - 1);
    // slow ticks per update, counted modulo 32
    localparam logic [4:0] SLOW_PER_UPDATE_LAST = 5'h1F;
    localparam logic [7:0] NO_FLOW_LIMIT = 8'h0F;
    localparam logic [15:0] LO_MAX = 16'hFFFF;
    localparam logic [7:0] HI_MAX = 8'hFF;
    localparam logic [23:0] CAPTURE_LATENCY_US = 24'h000014;
    localparam logic [31:0] FLOW_SCALE = 32'h005B_8D80;
    localparam logic [15:0] DISPLAY_MAX = 16'h03E7;
    localparam logic [9:0] TEMP_BASE = 10'h200;
    localparam logic [8:0] PRES_BASE = 9'h100;
    localparam int COMP_SHIFT = 9;
    localparam logic [1:0] CH_PRESSURE = 2'h0;
    localparam logic [1:0] CH_TEMPERATURE = 2'h1;
    localparam logic [1:0] CH_SETPOINT = 2'h2;
    localparam logic [7:0] SEG_E = 8'h79;
    localparam logic [7:0] SEG_DP = 8'h80;
    localparam logic [7:0] SEG_OFF = 8'h00;
    localparam logic [7:0] LED_FLOW = 8'h01;
    localparam logic [7:0] LED_TEMP = 8'h02;
    localparam logic [7:0] LED_PRES = 8'h04;
    localparam logic [7:0] LED_SET = 8'h08;
    localparam logic [15:0] TEN = 16'h000A;
    localparam logic [15:0] HUNDRED = 16'h0064;

    typedef enum logic [1:0] {POS_TENS, POS_ONES, POS_TENTHS, POS_LEDS} afm_pos_type;
    typedef enum logic [1:0] {VIEW_FLOW, VIEW_TEMP, VIEW_PRES, VIEW_SET} afm_view_type;
    typedef enum logic [2:0] {
        M_CALC, M_TEMP_REQ, M_TEMP_WAIT, M_PRES_REQ, M_PRES_WAIT, M_SET_REQ, M_SET_WAIT,
        M_DISPLAY
    } afm_main_type;

    typedef struct packed {
        logic [7:0] temperature;
        logic [7:0] pressure;
        logic [7:0] setpoint;
    } afm_readings_type;

    typedef struct packed {
        logic [7:0] tens;
        logic [7:0] ones;
        logic [7:0] tenths;
        logic [7:0] leds;
    } afm_display_type;

    // segment pattern, bit0 = a .. bit6 = g, bit7 = dp
    function automatic logic [7:0] seg_of(input logic [3:0] d);
        case (d)
            4'h0: seg_of = 8'h3F;
            4'h1: seg_of = 8'h06;
            4'h2: seg_of = 8'h5B;
            4'h3: seg_of = 8'h4F;
            4'h4: seg_of = 8'h66;
            4'h5: seg_of = 8'h6D;
            4'h6: seg_of = 8'h7D;
            4'h7: seg_of = 8'h07;
            4'h8: seg_of = 8'h7F;
            4'h9: seg_of = 8'h6F;
            default: seg_of = SEG_OFF;
        endcase
    endfunction
endpackage

// [test/afm_props.sv]
// port assertions for the airflow meter controller
`timescale 1ns/1ns
module afm_props #(
    parameter int REFRESH_CYCLES = 20, // clocks per refresh tick
    parameter int SLOW_CYCLES = 8 // clocks per slow tick
) (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic tach_n, // tachometer
    input wire logic btn_a_n, // first button
    input wire logic btn_b_n, // second button
    input wire logic adc_done, // result valid
    input wire logic [7:0] adc_data, // result
    input wire logic adc_start, // request
    input wire logic [1:0] adc_chan, // channel
    input wire logic [7:0] seg, // segments
    input wire logic [3:0] disp_en, // enables
    input wire logic relay, // relay
    input wire logic no_flow_flag // no flow
);
    logic [3:0] prev_en;
    int hold_cnt;
    int quiet;
    logic waiting;
    logic started;
    logic [1:0] last_ch;
    logic [1:0] exp_ch;
    assign exp_ch = !started ? 2'h1 : last_ch == 2'h1 ? 2'h0 : last_ch == 2'h0 ? 2'h2 : 2'h1;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prev_en <= 4'h0;
            hold_cnt <= 0;
            quiet <= 0;
            waiting <= 1'b0;
            started <= 1'b0;
            last_ch <= 2'h0;
        end else begin
            prev_en <= disp_en;
            hold_cnt <= disp_en != prev_en ? 0 : hold_cnt + 1;
            quiet <= $fell(tach_n) ? 0 : quiet + 1;
            waiting <= adc_start | (waiting & ~adc_done);
            started <= started | adc_start;
            last_ch <= adc_start ? adc_chan : last_ch;
        end
    end
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    a_en_step: assert property (
        disp_en != prev_en |-> disp_en == (prev_en == 4'h0 ? 4'h2 : {prev_en[2:0], prev_en[3]}))
        else $error("display enable skipped a position");
    a_en_hold: assert property (
        disp_en != prev_en && prev_en != 4'h0 |-> hold_cnt == REFRESH_CYCLES - 1)
        else $error("refresh period wrong");
    a_start_pulse: assert property (
        adc_start |-> !waiting ##1 !adc_start) else $error("bad converter start");
    a_chan_order: assert property (
        adc_start |-> adc_chan == exp_ch) else $error("converter channel out of order");
    a_start_gap: assert property (
        adc_done && waiting && adc_chan != 2'h2 |-> ##2 adc_start)
        else $error("next conversion late");
    a_relay_cause: assert property (
        $changed(relay) |-> adc_chan == 2'h2 && ($past(adc_done) || $past(adc_done, 2)))
        else $error("relay moved without setpoint reading");
    // blank until the first update has been taken
    a_led_view: assert property (
        disp_en == 4'h8 && seg != 8'h00 |-> $onehot(seg[3:0]) && seg[7:4] == 4'h0)
        else $error("indicator pattern not one-hot");
    // the no-flow E pattern carries no decimal point
    a_dp_ones: assert property (
        disp_en != 4'h0 && disp_en != 4'h8 && seg != 8'h00 && seg != 8'h79
        |-> seg[7] == disp_en[1])
        else $error("decimal point misplaced");
    a_flag_late: assert property (
        no_flow_flag |-> quiet > 104857000) else $error("no-flow set too early");
    a_flag_clear: assert property (
        $fell(tach_n) |-> ##[1:3] !no_flow_flag) else $error("no-flow kept after pulse");
    c_set_done: cover property (adc_done && adc_chan == 2'h2);
    c_relay_on: cover property ($rose(relay));
    c_set_view: cover property (disp_en == 4'h8 && seg == 8'h08);
endmodule
bind afm_controller afm_props #(.REFRESH_CYCLES(REFRESH_CYCLES), .SLOW_CYCLES(SLOW_CYCLES))
    i_afm_props (.clk(clk), .rst(rst), .tach_n(tach_n), .btn_a_n(btn_a_n), .btn_b_n(btn_b_n),
    .adc_done(adc_done), .adc_data(adc_data), .adc_start(adc_start), .adc_chan(adc_chan),
    .seg(seg), .disp_en(disp_en), .relay(relay), .no_flow_flag(no_flow_flag));

// [test/afm_far_side.sv]
// converter and tachometer model facing the controller
`timescale 1ns/1ns
module afm_far_side (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire afm_pkg::afm_readings_type rd, // channel values
    input wire logic [7:0] lag, // cycles before a result
    input wire logic [15:0] tach_period, // clocks per pulse, 0 stops
    input wire logic adc_start, // request
    input wire logic [1:0] adc_chan, // channel
    output logic adc_done, // result valid
    output logic [7:0] adc_data, // result
    output logic tach_n // pulse train
);
    logic busy;
    logic [7:0] cnt;
    logic [1:0] ch;
    logic [15:0] tcnt;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            ch <= 2'h0;
            adc_done <= 1'b0;
            adc_data <= 8'h5A;
            tach_n <= 1'b1;
            tcnt <= 16'h0000;
        end else begin
            adc_done <= 1'b0;
            // data only valid with done; flips otherwise
            adc_data <= ~adc_data;
            if (adc_start) begin
                busy <= 1'b1;
                cnt <= lag;
                ch <= adc_chan;
            end else if (busy && cnt == 8'h00) begin
                busy <= 1'b0;
                adc_done <= 1'b1;
                adc_data <= ch == afm_pkg::CH_PRESSURE ? rd.pressure :
                    ch == afm_pkg::CH_TEMPERATURE ? rd.temperature : rd.setpoint;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
            tcnt <= (tach_period == 16'h0000 || tcnt == tach_period - 16'h0001) ? 16'h0000
                : tcnt + 16'h0001;
            // two clocks low per period keeps duty far below a tenth
            tach_n <= tach_period == 16'h0000 || tcnt >= 16'h0002;
        end
    end
endmodule

// [test/tb_afm_controller.sv]
// self-checking bench for the airflow meter controller
`timescale 1ns/1ns
module tb_afm_controller;
    typedef struct packed {
        logic a;
        logic b;
        logic [7:0] sp;
        logic [7:0] lag;
        logic rly;
        logic [31:0] disp;
    } afm_row_type;
    // flow 999 clamped, temp 2 gives 995, pressure 10 gives 516
    localparam afm_row_type ROWS [5] = '{
        '{1'b1, 1'b1, 8'h80, 8'h02, 1'b1, 32'h6D867D01},
        '{1'b1, 1'b1, 8'h81, 8'h1E, 1'b0, 32'h6D867D01},
        '{1'b0, 1'b1, 8'h81, 8'h02, 1'b0, 32'h3FBF5B02},
        '{1'b1, 1'b0, 8'h80, 8'h1E, 1'b1, 32'h3F863F04},
        '{1'b0, 1'b0, 8'h80, 8'h02, 1'b1, 32'h6D865B08}};
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic btn_a_n = 1'b1;
    logic btn_b_n = 1'b1;
    logic [7:0] lag = 8'h02;
    logic [15:0] tach_period = 16'h0000;
    afm_pkg::afm_readings_type rd = '{8'h02, 8'h0A, 8'h00};
    logic tach_n, adc_done, adc_start, relay, no_flow_flag;
    logic [7:0] adc_data, seg;
    logic [1:0] adc_chan;
    logic [3:0] disp_en;
    logic [7:0] shown [4];
    int led_moves = 0, bad_count = 0, n_tests = 0;
    always #5 clk = ~clk;
    afm_controller #(.REFRESH_CYCLES(20), .SLOW_CYCLES(8)) i_afm_controller (.clk(clk),
        .rst(rst), .tach_n(tach_n), .btn_a_n(btn_a_n), .btn_b_n(btn_b_n), .adc_done(adc_done),
        .adc_data(adc_data), .adc_start(adc_start), .adc_chan(adc_chan), .seg(seg),
        .disp_en(disp_en), .relay(relay), .no_flow_flag(no_flow_flag));
    afm_far_side i_afm_far_side (.clk(clk), .rst(rst), .rd(rd), .lag(lag),
        .tach_period(tach_period), .adc_start(adc_start), .adc_chan(adc_chan),
        .adc_done(adc_done), .adc_data(adc_data), .tach_n(tach_n));
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (disp_en[i] === 1'b1) begin
                if (i == 3 && shown[3] !== seg) begin
                    led_moves++;
                end
                shown[i] = seg;
            end
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    task automatic test_done();
        if (bad_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic dark();
        chk(seg, 8'h00);
        chk({4'h0, disp_en}, 8'h00);
        chkb(relay, 1'b0);
        chkb(adc_start, 1'b0);
        chkb(no_flow_flag, 1'b0);
    endtask
    task automatic run_row(input afm_row_type r);
        @(posedge clk);
        #1;
        btn_a_n = r.a;
        btn_b_n = r.b;
        rd.setpoint = r.sp;
        lag = r.lag;
        repeat (700) @(posedge clk);
        #1;
        chkb(relay, r.rly);
        for (int i = 0; i < 4; i++) begin
            chk(shown[i], r.disp[31 - 8 * i -: 8]);
        end
    endtask
    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        dark();
        rst = 1'b0;
        repeat (300) @(posedge clk);
        #1;
        chkb(relay, 1'b0);
        chkb(no_flow_flag, 1'b0);
        tach_period = 16'h03E8;
        repeat (3000) @(posedge clk);
        foreach (ROWS[i]) begin
            run_row(ROWS[i]);
        end
        led_moves = 0;
        // buttons bounce faster than the update interval
        repeat (25) begin
            repeat (10) @(posedge clk);
            #1;
            btn_a_n = ~btn_a_n;
        end
        chkb(led_moves <= 1, 1'b1);
        @(posedge clk);
        #1;
        rst = 1'b1;
        @(posedge clk);
        #1;
        dark();
        rst = 1'b0;
        run_row(ROWS[0]);
        test_done();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        test_done();
    end
endmodule
